// ### logic/bdcs_regs.vh
// Constants for the bridge driver control front end: offsets, fields, resets, timing
`ifndef BDCS_REGS_VH
`define BDCS_REGS_VH

// Serial word layout
`define BDCS_WORD_W            16
`define BDCS_WORD_BITS         5'd16
`define BDCS_SEL_MSB           15
`define BDCS_SEL_LSB           13
`define BDCS_DATA_MSB          12
`define BDCS_DATA_LSB          0

// Serial register selectors
`define BDCS_SEL_TIMING        3'h0
`define BDCS_SEL_DETECT        3'h1
`define BDCS_SEL_MODE          3'h2
`define BDCS_SEL_BRIDGE        3'h3

// Avalon word indices (byte address bits [4:2])
`define BDCS_IDX_TIMING        3'h0
`define BDCS_IDX_DETECT        3'h1
`define BDCS_IDX_MODE          3'h2
`define BDCS_IDX_BRIDGE        3'h3
`define BDCS_IDX_STATUS        3'h4
`define BDCS_IDX_LAST_RX       3'h5

// Timing register fields
`define BDCS_DT_MSB            5
`define BDCS_DT_LSB            0
`define BDCS_BLANK_MSB         11
`define BDCS_BLANK_LSB         6
// Detect register fields
`define BDCS_VDS_MSB           5
`define BDCS_VDS_LSB           0
`define BDCS_OLT_MSB           8
`define BDCS_OLT_LSB           6
`define BDCS_OLI_BIT           9
`define BDCS_PHT_MSB           12
`define BDCS_PHT_LSB           10
// Mode register fields
`define BDCS_FAULT_INDICATOR_OUT_MSB          1
`define BDCS_FAULT_INDICATOR_OUT_LSB          0
`define BDCS_VRG_BIT           2
`define BDCS_MON_BIT           3
// Bridge command bits
`define BDCS_CMD_A_TOP         0
`define BDCS_CMD_A_BOT         1
`define BDCS_CMD_B_TOP         2
`define BDCS_CMD_B_BOT         3

// Diagnostic output functions
`define BDCS_FAULT_INDICATOR_OUT_FLAG         2'h0
`define BDCS_FAULT_INDICATOR_OUT_PULSE        2'h1
`define BDCS_FAULT_INDICATOR_OUT_TEMP         2'h2
`define BDCS_FAULT_INDICATOR_OUT_OFFSET       2'h3

// Reset values
`define BDCS_TIMING_RESET      13'h0204
`define BDCS_DETECT_RESET      13'h0010
`define BDCS_MODE_RESET        13'h0004
`define BDCS_BRIDGE_RESET      4'h0

// Timing
`define BDCS_CLK_PERIOD_NS     40
`define BDCS_SLEEP_HOLD_NS     20000
`define BDCS_SLEEP_HOLD_CYCLES ((`BDCS_SLEEP_HOLD_NS + `BDCS_CLK_PERIOD_NS - 1) / `BDCS_CLK_PERIOD_NS)
`define BDCS_EN_TIMEOUT_NS     40000
`define BDCS_EN_TIMEOUT_CYCLES ((`BDCS_EN_TIMEOUT_NS + `BDCS_CLK_PERIOD_NS - 1) / `BDCS_CLK_PERIOD_NS)
`define BDCS_FP_PERIOD_NS      100000000
`define BDCS_FP_PERIOD_CYCLES  (`BDCS_FP_PERIOD_NS / `BDCS_CLK_PERIOD_NS)
`define BDCS_FP_DUTY_FAULT     80
`define BDCS_FP_DUTY_OK        20

`endif

// ### logic/bdcs_top.v
// Bridge driver control front end: serial port, bridge logic, diagnostics, Avalon registers
`include "bdcs_regs.vh"
`default_nettype none

// Overview of operation
// [RULE1] Serial words are 16 bits, msb first
// [RULE2] Data sampled on each shift clock rise
// [RULE3] Host gives sixteen rising edges per frame
// [RULE4] Host keeps shift clock high at strobe edges
// [RULE5] Strobe high: ignore pins, output released
// [RULE6] Fault flag appears at strobe fall
// [RULE7] Diagnostic output has four functions, flag default
// [RULE8] Short reset pulse clears latched faults
// [RULE9] Reset held low enters sleep
// [RULE10] Enable low kills drives, direct or timed
// [RULE11] Enable kill bypasses serial and decode logic
// [RULE12] Leg A top input active high
// [RULE13] Leg B top input active low
// [RULE14] Leg A bottom input active low
// [RULE15] Leg B bottom input active high
// [RULE16] One PWM alternates a leg's switches
// [RULE17] Top and bottom never on together
// [RULE18] Dead time inserted on every changeover
// [RULE19] Serial port reaches all programmable settings
// [RULE20] Supply select bit: one 13 V, zero 8 V
// [RULE21] Per-leg state output from comparator
// [RULE22] Power-on reset returns all logic to reset
// [RULE23] Conflicting combined requests leave leg off
// [RULE24] Status shifts out msb first per clock
// [RULE25] Word applied only after exactly sixteen edges
module bdcs_top #(
	parameter integer FP_PERIOD_CYCLES = `BDCS_FP_PERIOD_CYCLES
)(
	input  wire        CLK_SYS,
	input  wire        RSTN,
	input  wire [4:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	output wire [31:0] AVS_READDATA,
	output wire        AVS_WAITREQUEST,
	input  wire        LEG_A_TOP_CMD,
	input  wire        LEG_B_TOP_CMD_N,
	input  wire        LEG_A_BOTTOM_CMD_N,
	input  wire        LEG_B_BOTTOM_CMD,
	input  wire        SERIAL_SELECT_N,
	input  wire        SERIAL_CLK,
	input  wire        SERIAL_DATA_IN,
	output wire        SERIAL_DATA_OUT,
	output wire        SERIAL_DATA_OUT_OE,
	input  wire        CLEAR_AND_SLEEP_N,
	input  wire        ENABLE_IN,
	input  wire        LEG_A_CMP,
	input  wire        LEG_B_CMP,
	input  wire [7:0]  FAULT_IN,
	output wire        FAULT_INDICATOR_OUT,
	output wire [1:0]  FAULT_INDICATOR_OUT_ANALOG_SEL,
	output wire        TOP_GATE_DRIVE_A,
	output wire        TOP_GATE_DRIVE_B,
	output wire        BOTTOM_GATE_DRIVE_A,
	output wire        BOTTOM_GATE_DRIVE_B,
	output wire        LEG_A_STATE_OUT,
	output wire        LEG_B_STATE_OUT,
	output wire        GATE_SUPPLY_LEVEL_SEL,
	output wire        SLEEP_MODE,
	output wire [5:0]  VDS_THRESHOLD,
	output wire [5:0]  BLANK_TIME,
	output wire [2:0]  OPEN_LOAD_THRESHOLD,
	output wire        OPEN_LOAD_CURRENT,
	output wire [2:0]  PHASE_THRESHOLD
);

	localparam integer SYNC_W = 19;
	// Idle levels of every synchronised pin, so reset never fakes an edge
	localparam [18:0] SYNC_IDLE = {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
	localparam integer SLEEP_HOLD = `BDCS_SLEEP_HOLD_CYCLES;
	localparam integer EN_TIMEOUT = `BDCS_EN_TIMEOUT_CYCLES;
	localparam integer FP_LAST = FP_PERIOD_CYCLES - 1;
	localparam integer FP_HI_FAULT = (FP_PERIOD_CYCLES * `BDCS_FP_DUTY_FAULT) / 100;
	localparam integer FP_HI_OK = (FP_PERIOD_CYCLES * `BDCS_FP_DUTY_OK) / 100;

	// Single-request decode of one leg: {top only, bottom only}
	function [1:0] leg_target;
		input top_req;
		input bot_req;
		begin
			leg_target = {top_req & ~bot_req, bot_req & ~top_req};
		end
	endfunction
	reg                 rst_meta, rst_n;
	reg  [SYNC_W-1:0]   sync1, sync2;
	reg                 sel_n_d, sck_d, clr_n_d;
	reg  [15:0]         rx_shift, tx_shift, last_rx;
	reg  [4:0]          rx_count;
	reg                 serial_data_out, sdo_oe;
	reg  [12:0]         cfg_timing, cfg_detect, cfg_mode;
	reg  [3:0]          bridge_cmd;
	reg  [7:0]          fault_latch;
	reg  [11:0]         low_cnt, en_low_cnt;
	reg                 sleep, fault_indicator_out_out, bus_ack;
	reg  [1:0]          top_on, bot_on, top_gate, bot_gate, leg_state;
	reg  [5:0]          dead_cnt [0:1];
	reg  [23:0]         fp_cnt;
	reg  [31:0]         readdata, rd_mux;
	integer             i;
	wire        sel_n    = sync2[18];
	wire        sck      = sync2[17];
	wire        serial_data_in      = sync2[16];
	wire        clr_n    = sync2[15];
	wire        enable   = sync2[14];
	wire [1:0]  cmp      = {sync2[12], sync2[13]};
	wire [7:0]  fault_live = sync2[7:0];
	wire [1:0]  pin_top  = {~sync2[10], sync2[11]};                       // [RULE12] [RULE13]
	wire [1:0]  pin_bot  = {sync2[8], ~sync2[9]};                         // [RULE14] [RULE15]
	wire [1:0]  ser_top  = {bridge_cmd[`BDCS_CMD_B_TOP], bridge_cmd[`BDCS_CMD_A_TOP]};
	wire [1:0]  ser_bot  = {bridge_cmd[`BDCS_CMD_B_BOT], bridge_cmd[`BDCS_CMD_A_BOT]};
	wire [1:0]  top_req  = pin_top | ser_top;                              // [RULE16] [RULE23]
	wire [1:0]  bot_req  = pin_bot | ser_bot;
	wire [3:0]  tgt_all  = {leg_target(top_req[1], bot_req[1]), leg_target(top_req[0], bot_req[0])}; // [RULE23]
	wire        frame_start = sel_n_d & ~sel_n;
	wire        frame_end   = ~sel_n_d & sel_n;
	wire        sck_rise    = ~sel_n & ~sck_d & sck;                      // [RULE5]
	wire        sck_fall    = ~sel_n & sck_d & ~sck;
	wire        rx_commit   = frame_end & (rx_count == `BDCS_WORD_BITS);  // [RULE25]
	wire [2:0]  rx_sel      = rx_shift[`BDCS_SEL_MSB:`BDCS_SEL_LSB];
	wire [12:0] rx_data     = rx_shift[`BDCS_DATA_MSB:`BDCS_DATA_LSB];
	wire        gen_fault   = (|fault_latch) | (|fault_live);
	wire [15:0] status_word = {gen_fault, leg_state[1], leg_state[0], sleep, enable, 3'h0, fault_latch};
	wire        clear_pulse = clr_n_d & ~clr_n;                           // [RULE8]
	wire        monitor     = cfg_mode[`BDCS_MON_BIT];
	wire        kill        = sleep | (~enable & (~monitor | (en_low_cnt >= EN_TIMEOUT))); // [RULE10] [RULE9]
	wire [5:0]  dead_time   = cfg_timing[`BDCS_DT_MSB:`BDCS_DT_LSB];
	wire [1:0]  fault_indicator_out_mode   = cfg_mode[`BDCS_FAULT_INDICATOR_OUT_MSB:`BDCS_FAULT_INDICATOR_OUT_LSB];
	wire        bus_req  = AVS_READ | AVS_WRITE;
	wire        bus_wr   = AVS_WRITE & bus_ack;
	wire [2:0]  bus_idx  = AVS_ADDRESS[4:2];
	wire [7:0]  w1c_mask = (bus_wr && bus_idx == `BDCS_IDX_STATUS) ? AVS_WRITEDATA[7:0] : 8'h00;

	// Reset release; assertion stays asynchronous
	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Pin synchronisers; only sync2 feeds logic
	always @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
		end
		else
		begin
			sync1 <= {SERIAL_SELECT_N, SERIAL_CLK, SERIAL_DATA_IN, CLEAR_AND_SLEEP_N, ENABLE_IN,
				LEG_A_CMP, LEG_B_CMP, LEG_A_TOP_CMD, LEG_B_TOP_CMD_N, LEG_A_BOTTOM_CMD_N,
				LEG_B_BOTTOM_CMD, FAULT_IN};
			sync2 <= sync1;
		end
	end

	// Serial port: receive, edge count, status shift-out
	always @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_n_d  <= 1'b1;
			sck_d    <= 1'b0;
			rx_shift <= 16'h0000;
			rx_count <= 5'h00;
			tx_shift <= 16'h0000;
			serial_data_out      <= 1'b0;
			sdo_oe   <= 1'b0;
			last_rx  <= 16'h0000;
		end
		else
		begin
			sel_n_d <= sel_n;
			sck_d   <= sck;
			sdo_oe  <= ~sel_n;                                              // [RULE5]
			if (frame_start)
			begin
				rx_count <= 5'h00;
				tx_shift <= status_word;
				serial_data_out      <= status_word[15];                               // [RULE6]
			end
			else
			begin
				if (sck_rise)
				begin
					rx_shift <= {rx_shift[14:0], serial_data_in};                     // [RULE1] [RULE2]
					// Saturate so long frames stay distinguishable from sixteen
					if (rx_count != 5'h11)
						rx_count <= rx_count + 5'h01;
				end
				if (sck_fall)
				begin
					tx_shift <= {tx_shift[14:0], 1'b0};                    // [RULE24]
					serial_data_out      <= tx_shift[14];
				end
			end
			if (rx_commit)
				last_rx <= rx_shift;
		end
	end

	// Settings: serial writes first, so a bus write in the same cycle wins
	always @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_timing <= `BDCS_TIMING_RESET;                              // [RULE22]
			cfg_detect <= `BDCS_DETECT_RESET;
			cfg_mode   <= `BDCS_MODE_RESET;                                // [RULE7]
			bridge_cmd <= `BDCS_BRIDGE_RESET;
		end
		else
		begin
			if (rx_commit)
			begin
				case (rx_sel)                                              // [RULE19]
					`BDCS_SEL_TIMING: cfg_timing <= rx_data;
					`BDCS_SEL_DETECT: cfg_detect <= rx_data;
					`BDCS_SEL_MODE:   cfg_mode   <= rx_data;
					`BDCS_SEL_BRIDGE: bridge_cmd <= rx_data[3:0];
					default:          cfg_mode   <= cfg_mode;
				endcase
			end
			if (bus_wr)
			begin
				case (bus_idx)
					`BDCS_IDX_TIMING: cfg_timing <= AVS_WRITEDATA[12:0];
					`BDCS_IDX_DETECT: cfg_detect <= AVS_WRITEDATA[12:0];
					`BDCS_IDX_MODE:   cfg_mode   <= AVS_WRITEDATA[12:0];
					`BDCS_IDX_BRIDGE: bridge_cmd <= AVS_WRITEDATA[3:0];
					default:          cfg_mode   <= cfg_mode;
				endcase
			end
		end
	end

	// Fault latch, clear and sleep, enable timeout
	always @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clr_n_d     <= 1'b1;
			fault_latch <= 8'h00;
			low_cnt     <= 12'h000;
			sleep       <= 1'b0;
			en_low_cnt  <= 12'h000;
		end
		else
		begin
			clr_n_d <= clr_n;
			// A new fault in the clearing cycle survives
			fault_latch <= (fault_latch & ~(w1c_mask | {8{clear_pulse}})) | fault_live; // [RULE8]
			if (clr_n)
			begin
				low_cnt <= 12'h000;
				sleep   <= 1'b0;
			end
			else if (low_cnt != SLEEP_HOLD)
				low_cnt <= low_cnt + 12'h001;
			else
				sleep <= 1'b1;                                             // [RULE9]
			if (enable)
				en_low_cnt <= 12'h000;
			else if (en_low_cnt != EN_TIMEOUT)
				en_low_cnt <= en_low_cnt + 12'h001;                        // [RULE10]
		end
	end

	// Per-leg drive sequencing with dead time
	always @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			top_on      <= 2'b00;
			bot_on      <= 2'b00;
			dead_cnt[0] <= 6'h00;
			dead_cnt[1] <= 6'h00;
			top_gate    <= 2'b00;
			bot_gate    <= 2'b00;
			leg_state   <= 2'b00;
		end
		else
		begin
			leg_state <= cmp;                                              // [RULE21]
			for (i = 0; i < 2; i = i + 1)
			begin
				if (kill)
				begin
					top_on[i]   <= 1'b0;
					bot_on[i]   <= 1'b0;
					dead_cnt[i] <= dead_time;
				end
				else if ({top_on[i], bot_on[i]} == {tgt_all[2*i+1], tgt_all[2*i]})
					dead_cnt[i] <= dead_cnt[i];
				else if (top_on[i] | bot_on[i])
				begin
					top_on[i]   <= 1'b0;                                   // [RULE18]
					bot_on[i]   <= 1'b0;
					dead_cnt[i] <= dead_time;
				end
				else if (dead_cnt[i] != 6'h00)
					dead_cnt[i] <= dead_cnt[i] - 6'h01;
				else
				begin
					top_on[i] <= tgt_all[2*i+1];
					bot_on[i] <= tgt_all[2*i];
				end
				// Kill and lockout act at the output stage itself
				top_gate[i] <= ~kill & top_on[i] & ~bot_on[i];             // [RULE11] [RULE17]
				bot_gate[i] <= ~kill & bot_on[i] & ~top_on[i];             // [RULE11] [RULE17]
			end
		end
	end

	// Diagnostic output; analog functions are routed by the select lines
	always @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fp_cnt   <= 24'h000000;
			fault_indicator_out_out <= 1'b0;
		end
		else
		begin
			fp_cnt <= (fp_cnt >= FP_LAST) ? 24'h000000 : fp_cnt + 24'h000001;
			case (fault_indicator_out_mode)                                               // [RULE7]
				`BDCS_FAULT_INDICATOR_OUT_FLAG:  fault_indicator_out_out <= gen_fault;
				`BDCS_FAULT_INDICATOR_OUT_PULSE: fault_indicator_out_out <= fp_cnt < (gen_fault ? FP_HI_FAULT : FP_HI_OK);
				default:          fault_indicator_out_out <= 1'b0;
			endcase
		end
	end
	always @*
	begin
		case (bus_idx)
			`BDCS_IDX_TIMING:  rd_mux = {19'h00000, cfg_timing};
			`BDCS_IDX_DETECT:  rd_mux = {19'h00000, cfg_detect};
			`BDCS_IDX_MODE:    rd_mux = {19'h00000, cfg_mode};
			`BDCS_IDX_BRIDGE:  rd_mux = {28'h0000000, bridge_cmd};
			`BDCS_IDX_STATUS:  rd_mux = {16'h0000, status_word};
			`BDCS_IDX_LAST_RX: rd_mux = {16'h0000, last_rx};
			default:           rd_mux = 32'h00000000;
		endcase
	end
	// One wait cycle per access; read data captured as the wait drops
	always @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_ack  <= 1'b0;
			readdata <= 32'h00000000;
		end
		else
		begin
			bus_ack <= bus_req & ~bus_ack;
			if (AVS_READ & ~bus_ack)
				readdata <= rd_mux;
		end
	end

	assign AVS_WAITREQUEST       = bus_req & ~bus_ack;
	assign AVS_READDATA          = readdata;
	assign SERIAL_DATA_OUT       = serial_data_out & sdo_oe;
	assign SERIAL_DATA_OUT_OE    = sdo_oe;
	assign FAULT_INDICATOR_OUT   = fault_indicator_out_out;
	assign FAULT_INDICATOR_OUT_ANALOG_SEL       = fault_indicator_out_mode;
	assign TOP_GATE_DRIVE_A      = top_gate[0];
	assign TOP_GATE_DRIVE_B      = top_gate[1];
	assign BOTTOM_GATE_DRIVE_A   = bot_gate[0];
	assign BOTTOM_GATE_DRIVE_B   = bot_gate[1];
	assign LEG_A_STATE_OUT       = leg_state[0];
	assign LEG_B_STATE_OUT       = leg_state[1];
	assign GATE_SUPPLY_LEVEL_SEL = cfg_mode[`BDCS_VRG_BIT];               // [RULE20]
	assign SLEEP_MODE            = sleep;
	assign VDS_THRESHOLD         = cfg_detect[`BDCS_VDS_MSB:`BDCS_VDS_LSB];
	assign BLANK_TIME            = cfg_timing[`BDCS_BLANK_MSB:`BDCS_BLANK_LSB];
	assign OPEN_LOAD_THRESHOLD   = cfg_detect[`BDCS_OLT_MSB:`BDCS_OLT_LSB];
	assign OPEN_LOAD_CURRENT     = cfg_detect[`BDCS_OLI_BIT];
	assign PHASE_THRESHOLD       = cfg_detect[`BDCS_PHT_MSB:`BDCS_PHT_LSB];

endmodule // bdcs_top

`default_nettype wire

// ### bench/bdcs_top_props.sv
// Port checker for the bridge driver control front end
`default_nettype none
module bdcs_props (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic SERIAL_SELECT_N,
	input wire logic SERIAL_DATA_OUT_OE,
	input wire logic CLEAR_AND_SLEEP_N,
	input wire logic ENABLE_IN,
	input wire logic TOP_GATE_DRIVE_A,
	input wire logic TOP_GATE_DRIVE_B,
	input wire logic BOTTOM_GATE_DRIVE_A,
	input wire logic BOTTOM_GATE_DRIVE_B,
	input wire logic GATE_SUPPLY_LEVEL_SEL,
	input wire logic SLEEP_MODE
);
	timeunit 1ns;
	timeprecision 1ns;
	// Saturating low-time counters, so long waits need no long repetitions
	logic [10:0] en_low;
	logic [10:0] slp_low;
	wire         any_on = TOP_GATE_DRIVE_A | TOP_GATE_DRIVE_B | BOTTOM_GATE_DRIVE_A | BOTTOM_GATE_DRIVE_B;
	always_ff @(posedge CLK_SYS or negedge RSTN)
		if (!RSTN)
		begin
			en_low <= 11'h000;
			slp_low <= 11'h000;
		end
		else
		begin
			en_low <= ENABLE_IN ? 11'h000 : en_low + 11'(en_low != 11'h7FF);
			slp_low <= CLEAR_AND_SLEEP_N ? 11'h000 : slp_low + 11'(slp_low != 11'h7FF);
		end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	a_lock_leg_a: assert property (!(TOP_GATE_DRIVE_A && BOTTOM_GATE_DRIVE_A))
		else $error("leg A top and bottom on together");
	a_lock_leg_b: assert property (!(TOP_GATE_DRIVE_B && BOTTOM_GATE_DRIVE_B))
		else $error("leg B top and bottom on together");
	// Reset dead time is four cycles and the bench never changes it
	a_dead_leg_a: assert property ($fell(TOP_GATE_DRIVE_A) |-> !BOTTOM_GATE_DRIVE_A [*4])
		else $error("leg A bottom on inside dead time");
	a_dead_leg_b: assert property ($fell(BOTTOM_GATE_DRIVE_B) |-> !TOP_GATE_DRIVE_B [*4])
		else $error("leg B top on inside dead time");
	a_sdo_release: assert property (SERIAL_SELECT_N [*6] |-> !SERIAL_DATA_OUT_OE)
		else $error("serial output driven while deselected");
	a_sdo_flag: assert property ($fell(SERIAL_SELECT_N) |-> ##[2:6] SERIAL_DATA_OUT_OE)
		else $error("serial output not driven after select");
	a_enable_kill: assert property (en_low > 11'd1010 |-> !any_on)
		else $error("gate drive on with enable long low");
	a_sleep_entry: assert property (slp_low >= 11'd510 |-> SLEEP_MODE && !any_on)
		else $error("no sleep after long clear pin low");
	a_sleep_exit: assert property (CLEAR_AND_SLEEP_N [*6] |-> !SLEEP_MODE)
		else $error("sleep persists after clear pin high");
	a_reset_state: assert property (disable iff (1'b0) !RSTN |=> GATE_SUPPLY_LEVEL_SEL && !SLEEP_MODE && !any_on)
		else $error("outputs not at reset values");
	c_sleep: cover property ($rose(SLEEP_MODE));
	c_frame: cover property ($rose(SERIAL_DATA_OUT_OE));
	c_swap: cover property ($fell(TOP_GATE_DRIVE_A) ##[1:20] BOTTOM_GATE_DRIVE_A);
endmodule // bdcs_props

bind bdcs_top bdcs_props props_u (
	.CLK_SYS(CLK_SYS),
	.RSTN(RSTN),
	.SERIAL_SELECT_N(SERIAL_SELECT_N),
	.SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE),
	.CLEAR_AND_SLEEP_N(CLEAR_AND_SLEEP_N),
	.ENABLE_IN(ENABLE_IN),
	.TOP_GATE_DRIVE_A(TOP_GATE_DRIVE_A),
	.TOP_GATE_DRIVE_B(TOP_GATE_DRIVE_B),
	.BOTTOM_GATE_DRIVE_A(BOTTOM_GATE_DRIVE_A),
	.BOTTOM_GATE_DRIVE_B(BOTTOM_GATE_DRIVE_B),
	.GATE_SUPPLY_LEVEL_SEL(GATE_SUPPLY_LEVEL_SEL),
	.SLEEP_MODE(SLEEP_MODE)
);
`default_nettype wire

// ### bench/bdcs_host.sv
// Serial host model: strobe, shift clock and data towards the device
`default_nettype none
module bdcs_host (
	output logic      select_n,
	output logic      sck,
	output logic      serial_data_in,
	input  wire logic serial_data_out,
	input  wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last = 1'b0;
	// Released line has no pull: show the inverse of the last driven bit
	wire  seen = sdo_oe ? serial_data_out : ~last;
	always @(serial_data_out or sdo_oe)
		if (sdo_oe)
			last = serial_data_out;
	initial
	begin
		select_n = 1'b1;
		sck = 1'b0;
		serial_data_in = 1'b0;
	end
	// Offset keeps shift clock edges clear of system clock edges
	task automatic xfer(input logic [15:0] word, input int edges, output logic [15:0] rx);
		logic [31:0] sh;
		sh = {word, 16'h0000};
		rx = 16'h0000;
		#7 sck = 1'b1;
		#200 select_n = 1'b0;
		#200 rx[15] = seen;
		for (int i = 0; i < edges; i++)
		begin
			#160 sck = 1'b0;
			serial_data_in = sh[31];
			sh = sh << 1;
			#160 sck = 1'b1;
			if (i < 15)
				rx[14 - i] = seen;
		end
		#200 select_n = 1'b1;
		#200 sck = 1'b0;
		serial_data_in = 1'b0;
	endtask
endmodule // bdcs_host
`default_nettype wire

// ### bench/bdcs_top_bench.sv
// Self-checking bench for the bridge driver control front end
`default_nettype none
module bdcs_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, ena = 1'b0, clr_n = 1'b1;
	logic        cmp_a = 1'b0, cmp_b = 1'b0, a_top = 1'b0, a_bot_n = 1'b1, b_top_n = 1'b1, b_bot = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic [31:0] wdata = 32'h0, rv, cnt;
	logic [7:0]  fault = 8'h00;
	logic [15:0] rx;
	wire  [31:0] rdata;
	wire         wait_req, serial_data_out, sdo_oe, sel_n, sck, serial_data_in, gta, gtb, gba, gbb, sta, stb, gate_supply_level_sel, sleep, olc, fio;
	wire  [1:0]  dsel;
	wire  [5:0]  vds, blank;
	wire  [2:0]  olt, pht;
	wire  [3:0]  gates = {gta, gba, gtb, gbb};
	int          failures = 0, checked = 0, cycles = 0;
	always #20 clk = ~clk;
	bdcs_top #(.FP_PERIOD_CYCLES(100)) dut_u (
		.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
		.LEG_A_TOP_CMD(a_top), .LEG_B_TOP_CMD_N(b_top_n), .LEG_A_BOTTOM_CMD_N(a_bot_n),
		.LEG_B_BOTTOM_CMD(b_bot), .SERIAL_SELECT_N(sel_n), .SERIAL_CLK(sck), .SERIAL_DATA_IN(serial_data_in),
		.SERIAL_DATA_OUT(serial_data_out), .SERIAL_DATA_OUT_OE(sdo_oe), .CLEAR_AND_SLEEP_N(clr_n),
		.ENABLE_IN(ena), .LEG_A_CMP(cmp_a), .LEG_B_CMP(cmp_b), .FAULT_IN(fault),
		.FAULT_INDICATOR_OUT(fio), .FAULT_INDICATOR_OUT_ANALOG_SEL(dsel), .TOP_GATE_DRIVE_A(gta),
		.TOP_GATE_DRIVE_B(gtb), .BOTTOM_GATE_DRIVE_A(gba), .BOTTOM_GATE_DRIVE_B(gbb),
		.LEG_A_STATE_OUT(sta), .LEG_B_STATE_OUT(stb), .GATE_SUPPLY_LEVEL_SEL(gate_supply_level_sel),
		.SLEEP_MODE(sleep), .VDS_THRESHOLD(vds), .BLANK_TIME(blank),
		.OPEN_LOAD_THRESHOLD(olt), .OPEN_LOAD_CURRENT(olc), .PHASE_THRESHOLD(pht)
	);
	bdcs_host host_u (.select_n(sel_n), .sck(sck), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .sdo_oe(sdo_oe));
	task stop_test;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Entered just after a rising edge; one idle edge follows each transfer
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		while (wait_req !== 1'b0)
			@(posedge clk);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task rdchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rv, e);
	endtask
	// High samples of the diagnostic output over one pulse period
	task hi_count(output logic [31:0] n);
		n = 32'h0;
		repeat (100)
		begin
			@(posedge clk);
			n = n + 32'(fio);
		end
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			failures++;
			stop_test;
		end
	end
	initial
	begin
		cyc(8);
		rstn <= 1'b1;
		cyc(6);
		rdchk(5'h00, 32'h204);
		rdchk(5'h04, 32'h10);
		rdchk(5'h0C, 32'h0);
		rdchk(5'h18, 32'h0);
		check(32'({gate_supply_level_sel, dsel, vds, blank}), 32'h4408);
		ena <= 1'b1;
		cyc(10);
		check(32'(gates), 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			bus(1'b1, 5'h08, 32'h4 + m);
			check(32'(dsel), m);
		end
		// Pulsed flag with no fault: a fifth of the period high
		bus(1'b1, 5'h08, 32'h5);
		hi_count(cnt);
		check(cnt, 32'h14);
		bus(1'b1, 5'h08, 32'h4);
		// Selector in the top three bits, data below, sent msb first
		host_u.xfer(16'h4000, 16, rx);
		cyc(6);
		check(32'(gate_supply_level_sel), 32'h0);
		host_u.xfer(16'h4004, 15, rx);
		cyc(6);
		check(32'(gate_supply_level_sel), 32'h0);
		host_u.xfer(16'h4004, 17, rx);
		cyc(6);
		check(32'(gate_supply_level_sel), 32'h0);
		host_u.xfer(16'h4004, 16, rx);
		cyc(6);
		check(32'(gate_supply_level_sel), 32'h1);
		rdchk(5'h14, 32'h4004);
		fault <= 8'h01;
		cmp_a <= 1'b1;
		cyc(8);
		host_u.xfer(16'h3E6B, 16, rx);
		cyc(6);
		check(32'(rx), 32'hA801);
		check(32'({pht, olc, olt, vds}), 32'h1E6B);
		check(32'({sta, stb}), 32'h2);
		check(32'(fio), 32'h1);
		// Pulsed flag with a fault: four fifths of the period high
		bus(1'b1, 5'h08, 32'h5);
		hi_count(cnt);
		check(cnt, 32'h50);
		bus(1'b1, 5'h08, 32'h4);
		a_top <= 1'b1;
		a_bot_n <= 1'b1;
		b_top_n <= 1'b1;
		b_bot <= 1'b1;
		cyc(14);
		check(32'(gates), 32'h9);
		a_top <= 1'b0;
		a_bot_n <= 1'b0;
		b_top_n <= 1'b0;
		b_bot <= 1'b0;
		cyc(16);
		check(32'(gates), 32'h6);
		bus(1'b1, 5'h0C, 32'h1);
		cyc(4);
		check(32'(gates), 32'h2);
		bus(1'b1, 5'h0C, 32'h0);
		a_top <= 1'b1;
		a_bot_n <= 1'b1;
		fault <= 8'h00;
		cyc(16);
		clr_n <= 1'b0;
		cyc(4);
		clr_n <= 1'b1;
		cyc(6);
		rdchk(5'h10, 32'h2800);
		check(32'({sleep, gates}), 32'h0A);
		check(32'(fio), 32'h0);
		clr_n <= 1'b0;
		cyc(520);
		check(32'({sleep, gates}), 32'h10);
		clr_n <= 1'b1;
		cyc(16);
		check(32'({sleep, gates}), 32'h0A);
		ena <= 1'b0;
		cyc(5);
		check(32'(gates), 32'h0);
		ena <= 1'b1;
		bus(1'b1, 5'h08, 32'hC);
		cyc(16);
		ena <= 1'b0;
		cyc(100);
		check(32'(gates), 32'hA);
		cyc(950);
		check(32'(gates), 32'h0);
		stop_test;
	end
endmodule // bdcs_top_bench
`default_nettype wire
